// ### link_cfg_block.sv
// Link configuration, credit status, static forwarding, bus slave
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/10ps
module link_cfg_block (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // AXI4-Lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [11:0] awaddr,
    // AXI4-Lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [11:0] araddr,
    // AXI4-Lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Link control toward link logic and pin muxing
    output logic [7:0] linkEnable,
    output logic [7:0] fiveWire,
    output logic [7:0] greetingSend,
    output logic [7:0] rxResync,
    // Link events from receiver and credit logic
    input wire logic [7:0] rxOverflow,
    input wire logic [7:0] rxIllegalToken,
    input wire logic [7:0] creditIssuedEvt,
    input wire logic [7:0] creditGrantEvt,
    // Transmit symbol handshake
    input wire logic [7:0] symValid,
    input wire logic [7:0] symLast,
    output logic [7:0] symReady,
    // Static forwarding, indexed by link number
    output logic [7:0] staticEn,
    output logic [7:0] staticProc,
    output logic [39:0] staticChanEnd,
    // Interrupt
    output logic irq
);

    typedef struct packed {
        logic [7:0] linkEn;
        logic [7:0] mode;
        logic [7:0] err;
        logic [7:0] issued;
        logic [7:0] held;
        logic [7:0] greet;
        logic [7:0] resync;
        logic [7:0][10:0] symGap;
        logic [7:0][10:0] tokGap;
        logic [7:0] stEn;
        logic [7:0] stProc;
        logic [7:0][4:0] stChan;
        logic [15:0] irqStat;
        logic [15:0] irqMask;
        logic awHave;
        logic [9:0] awIdx;
        logic wHave;
        logic [31:0] wData;
        logic [3:0] wStrb;
        logic bValid;
        logic [1:0] bResp;
        logic rValid;
        logic [31:0] rData;
        logic [1:0] rResp;
    } regs_s;

    regs_s q;
    regs_s d;
    logic wrCommit;

    // ****************************************
    // Decode helpers
    // ****************************************
    function automatic logic isLinkCfg(input logic [9:0] idx);
        isLinkCfg = (idx[9:3] == link_cfg_pkg::LINK_CFG_IDX[9:3]); // RULE10
    endfunction : isLinkCfg

    function automatic logic isStatic(input logic [9:0] idx);
        isStatic = (idx[9:3] == link_cfg_pkg::STATIC_IDX[9:3]);
    endfunction : isStatic

    // Static register order C, D, A, B, G, H, E, F to link number
    function automatic logic [2:0] staticLink(input logic [2:0] k);
        staticLink = k ^ 3'h2; // RULE14
    endfunction : staticLink

    function automatic logic [31:0] mergeBytes(input logic [31:0] old,
        input logic [31:0] nw, input logic [3:0] strb);
        mergeBytes = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                mergeBytes[8*b +: 8] = nw[8*b +: 8];
            end
        end
    endfunction : mergeBytes

    // Write-only action bits always read as zero
    function automatic logic [31:0] linkWord(input regs_s s,
        input logic [2:0] i);
        linkWord = {s.linkEn[i], s.mode[i], 2'h0, s.err[i], s.issued[i],
            s.held[i], 3'h0, s.symGap[i], s.tokGap[i]}; // RULE15
    endfunction : linkWord

    function automatic logic [31:0] staticWord(input regs_s s,
        input logic [2:0] k);
        staticWord = {s.stEn[k], 22'h000000, s.stProc[k], 3'h0,
            s.stChan[k]};
    endfunction : staticWord

    function automatic logic [31:0] readWord(input regs_s s,
        input logic [9:0] idx);
        if (isLinkCfg(idx)) begin
            readWord = linkWord(s, idx[2:0]);
        end else if (isStatic(idx)) begin
            readWord = staticWord(s, idx[2:0]);
        end else if (idx == link_cfg_pkg::IRQ_STAT_IDX) begin
            readWord = {16'h0000, s.irqStat};
        end else if (idx == link_cfg_pkg::IRQ_MASK_IDX) begin
            readWord = {16'h0000, s.irqMask};
        end else begin
            readWord = 32'h00000000;
        end
    endfunction : readWord

    function automatic logic isMapped(input logic [9:0] idx);
        isMapped = isLinkCfg(idx) || isStatic(idx)
            || (idx == link_cfg_pkg::IRQ_STAT_IDX)
            || (idx == link_cfg_pkg::IRQ_MASK_IDX);
    endfunction : isMapped

    // ****************************************
    // Bus handshakes
    // ****************************************
    // One write at a time: hold address and data until the response leaves
    assign awready = !q.awHave && !q.bValid;
    assign wready = !q.wHave && !q.bValid;
    assign arready = !q.rValid;
    assign wrCommit = q.awHave && q.wHave && !q.bValid;

    // ****************************************
    // Next state
    // ****************************************
    always_comb begin
        logic [2:0] li;
        logic [31:0] w;
        li = q.awIdx[2:0];
        w = 32'h00000000;
        d = q;
        d.greet = 8'h00; // RULE15
        d.resync = 8'h00; // RULE15

        if (awvalid && awready) begin
            d.awHave = 1'b1;
            d.awIdx = awaddr[11:2];
        end
        if (wvalid && wready) begin
            d.wHave = 1'b1;
            d.wData = wdata;
            d.wStrb = wstrb;
        end
        if (q.bValid && bready) begin
            d.bValid = 1'b0;
        end

        // Clears first, so hardware events below win over them on links enabled both before and after the write
        if (wrCommit) begin
            d.awHave = 1'b0;
            d.wHave = 1'b0;
            d.bValid = 1'b1;
            d.bResp = isMapped(q.awIdx) ? link_cfg_pkg::RESP_OKAY
                : link_cfg_pkg::RESP_SLVERR;
            if (isLinkCfg(q.awIdx)) begin
                w = mergeBytes(linkWord(q, li), q.wData, q.wStrb);
                d.linkEn[li] = w[link_cfg_pkg::LC_ENABLE]; // RULE1
                d.mode[li] = w[link_cfg_pkg::LC_MODE]; // RULE2
                d.symGap[li] = w[link_cfg_pkg::LC_SYMGAP_LSB +: 11]; // RULE8
                d.tokGap[li] = w[link_cfg_pkg::LC_TOKGAP_LSB +: 11]; // RULE9
                if (q.wStrb[3] && q.wData[link_cfg_pkg::LC_GREET]) begin
                    d.greet[li] = 1'b1; // RULE6
                    d.held[li] = 1'b0; // RULE6
                end
                if (q.wStrb[2] && q.wData[link_cfg_pkg::LC_RESYNC]) begin
                    d.resync[li] = 1'b1; // RULE7
                    d.err[li] = 1'b0;
                end
                // A disabled link holds no credit in either direction
                if (!w[link_cfg_pkg::LC_ENABLE]) begin
                    d.issued[li] = 1'b0;
                    d.held[li] = 1'b0;
                end
            end else if (isStatic(q.awIdx)) begin
                w = mergeBytes(staticWord(q, li), q.wData, q.wStrb);
                d.stEn[li] = w[link_cfg_pkg::SF_ENABLE]; // RULE11
                d.stProc[li] = w[link_cfg_pkg::SF_PROC]; // RULE12
                d.stChan[li] = w[link_cfg_pkg::SF_CHAN_LSB +: 5]; // RULE13
            end else if (q.awIdx == link_cfg_pkg::IRQ_STAT_IDX) begin
                w = mergeBytes(32'h00000000, q.wData, q.wStrb);
                d.irqStat = q.irqStat & ~w[15:0];
            end else if (q.awIdx == link_cfg_pkg::IRQ_MASK_IDX) begin
                w = mergeBytes({16'h0000, q.irqMask}, q.wData, q.wStrb);
                d.irqMask = w[15:0];
            end
        end

        // Link events: error in bits 7:0, credit received in bits 15:8
        for (int i = 0; i < 8; i++) begin
            if (d.linkEn[i] && q.linkEn[i]) begin
                if (rxOverflow[i] || rxIllegalToken[i]) begin
                    d.err[i] = 1'b1; // RULE3
                    d.irqStat[i] = 1'b1;
                end
                if (creditIssuedEvt[i]) begin
                    d.issued[i] = 1'b1; // RULE4
                end
                if (creditGrantEvt[i]) begin
                    d.held[i] = 1'b1; // RULE5
                    d.irqStat[8 + i] = 1'b1;
                end
            end
        end

        if (arvalid && arready) begin
            d.rValid = 1'b1;
            d.rData = readWord(q, araddr[11:2]);
            d.rResp = isMapped(araddr[11:2]) ? link_cfg_pkg::RESP_OKAY
                : link_cfg_pkg::RESP_SLVERR;
        end else if (q.rValid && rready) begin
            d.rValid = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= '0;
            q.irqStat <= link_cfg_pkg::IRQ_RST;
            q.irqMask <= link_cfg_pkg::IRQ_RST;
        end else begin
            q <= d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign bvalid = q.bValid;
    assign bresp = q.bResp;
    assign rvalid = q.rValid;
    assign rdata = q.rData;
    assign rresp = q.rResp;
    assign linkEnable = q.linkEn; // RULE1
    assign fiveWire = q.mode; // RULE2
    assign greetingSend = q.greet;
    assign rxResync = q.resync;
    assign irq = |(q.irqStat & q.irqMask);

    always_comb begin
        staticEn = 8'h00;
        staticProc = 8'h00;
        staticChanEnd = 40'h0000000000;
        for (int k = 0; k < 8; k++) begin
            staticEn[staticLink(3'(k))] = q.stEn[k]; // RULE14
            staticProc[staticLink(3'(k))] = q.stProc[k];
            staticChanEnd[5*staticLink(3'(k)) +: 5] = q.stChan[k];
        end
    end

    // Symbols pass only when the link is up and holds credit
    for (genvar g = 0; g < 8; g++) begin : g_pace
        link_tx_pacer u_pacer (
            .clk(clk),
            .nrst(nrst),
            .enable(q.linkEn[g] && q.held[g]),
            .gapSym(q.symGap[g]),
            .gapTok(q.tokGap[g]),
            .symValid(symValid[g]),
            .symLast(symLast[g]),
            .symReady(symReady[g])
        );
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);

    sequence s_cfgWrite;
        wrCommit && isLinkCfg(q.awIdx);
    endsequence

    sequence s_staticWrite;
        wrCommit && isStatic(q.awIdx);
    endsequence

    a_enable_write: assert property ( // RULE1
        (s_cfgWrite and (q.wStrb[3] == 1'b1))
        |=> linkEnable[$past(q.awIdx[2:0])] == $past(q.wData[31]))
        else $error("link enable did not follow write");

    a_mode_write: assert property ( // RULE2
        (s_cfgWrite and (q.wStrb[3] == 1'b1))
        |=> fiveWire[$past(q.awIdx[2:0])] == $past(q.wData[30]))
        else $error("wire mode did not follow write");

    a_error_set: assert property ( // RULE3
        (q.linkEn[0] && !wrCommit && rxIllegalToken[0]) |=> q.err[0])
        else $error("error flag not set by illegal token");

    a_credit_issued: assert property ( // RULE4
        (q.linkEn[0] && !wrCommit && creditIssuedEvt[0]) |=> q.issued[0])
        else $error("issued credit not reported");

    a_credit_held: assert property ( // RULE5
        (q.linkEn[0] && !wrCommit && creditGrantEvt[0]) |=> q.held[0])
        else $error("held credit not reported");

    a_tx_gate: assert property ( // RULE5
        (symReady & ~(q.linkEn & q.held)) == 8'h00)
        else $error("symbol accepted without held credit");

    a_greet_clear: assert property ( // RULE6
        (s_cfgWrite and (q.wStrb[3] && q.wData[24] && q.awIdx[2:0] == 3'h0
        && !creditGrantEvt[0])) |=> greetingSend[0] && !q.held[0])
        else $error("greeting did not clear credit");

    a_resync_pulse: assert property ( // RULE7
        (s_cfgWrite and (q.wStrb[2] && q.wData[23]))
        |=> rxResync[$past(q.awIdx[2:0])] ##1 (rxResync == 8'h00))
        else $error("receiver reset pulse wrong");

    a_greet_single: assert property ( // RULE15
        (greetingSend != 8'h00) |=> (greetingSend == 8'h00))
        else $error("greeting pulse longer than one cycle");

    a_static_map: assert property ( // RULE14
        (s_staticWrite and (q.awIdx[2:0] == 3'h0 && q.wStrb[3]))
        |=> staticEn[2] == $past(q.wData[31]))
        else $error("static register zero not on link C");

    a_static_dest: assert property ( // RULE13
        (s_staticWrite and (q.awIdx[2:0] == 3'h2 && q.wStrb[0]))
        |=> staticChanEnd[4:0] == $past(q.wData[4:0]))
        else $error("static channel end not forwarded");

    a_static_proc: assert property ( // RULE12
        (s_staticWrite and (q.awIdx[2:0] == 3'h1 && q.wStrb[1]))
        |=> staticProc[3] == $past(q.wData[8]))
        else $error("static processor not forwarded");

    a_static_en: assert property ( // RULE11
        (s_staticWrite and (q.awIdx[2:0] == 3'h6 && q.wStrb[3]))
        |=> staticEn[4] == $past(q.wData[31]))
        else $error("static enable not forwarded");

    a_write_resp: assert property (
        wrCommit |=> bvalid ##0 (bresp == (isMapped($past(q.awIdx))
        ? link_cfg_pkg::RESP_OKAY : link_cfg_pkg::RESP_SLVERR)))
        else $error("write response wrong");

endmodule : link_cfg_block

// ### link_cfg_pkg.sv
// Constants and types shared by the link configuration block
// Function
// RULE1: Enable bit turns link on or off and steers shared pin muxing.
// RULE2: Mode bit picks two-wire signalling at zero, five-wire at one.
// RULE3: Read-only error flag sets on receive overflow or illegal token.
// RULE4: Read-only bit shows this end has issued credit to remote end.
// RULE5: Read-only bit shows this end holds credit to transmit.
// RULE6: Writing the greeting bit clears own credit and sends a greeting.
// RULE7: Receiver reset bit makes the next symbol start a new token.
// RULE8: At least programmed-plus-one idle clocks between symbols in a token.
// RULE9: At least programmed-plus-one idle clocks between transmitted tokens.
// RULE10: One configuration register per external link, links zero to seven.
// RULE11: Static enable sends all received traffic to one channel end.
// RULE12: One-bit field picks destination processor for static traffic.
// RULE13: Five-bit field picks destination channel end for static traffic.
// RULE14: Static registers, ascending, serve links C, D, A, B, G, H, E, F.
// RULE15: Greeting and receiver reset act as one-cycle pulses, read as zero.
package link_cfg_pkg;

    // ****************************************
    // Sizes
    // ****************************************
    localparam int NUM_LINKS = 8;
    localparam int GAP_W = 11;
    localparam int CHAN_W = 5;
    localparam int ADDR_W = 12;

    // ****************************************
    // Register indices (byte address is four times the index)
    // ****************************************
    localparam logic [9:0] LINK_CFG_IDX = 10'h080;
    localparam logic [9:0] STATIC_IDX = 10'h0a0;
    localparam logic [9:0] IRQ_STAT_IDX = 10'h0c0;
    localparam logic [9:0] IRQ_MASK_IDX = 10'h0c1;

    // ****************************************
    // Link configuration fields
    // ****************************************
    localparam int LC_ENABLE = 31;
    localparam int LC_MODE = 30;
    localparam int LC_ERROR = 27;
    localparam int LC_ISSUED = 26;
    localparam int LC_HELD = 25;
    localparam int LC_GREET = 24;
    localparam int LC_RESYNC = 23;
    localparam int LC_SYMGAP_LSB = 11;
    localparam int LC_TOKGAP_LSB = 0;

    // ****************************************
    // Static forwarding fields
    // ****************************************
    localparam int SF_ENABLE = 31;
    localparam int SF_PROC = 8;
    localparam int SF_CHAN_LSB = 0;

    // ****************************************
    // Reset values
    // ****************************************
    localparam logic [GAP_W-1:0] GAP_RST = 11'h000;
    localparam logic [CHAN_W-1:0] CHAN_RST = 5'h00;
    localparam logic [15:0] IRQ_RST = 16'h0000;

    // ****************************************
    // Bus responses
    // ****************************************
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic {
        PACE_OPEN = 1'b0,
        PACE_WAIT = 1'b1
    } pace_e;

endpackage : link_cfg_pkg

// ### link_far_end.sv
// Remote link end model: link events and a symbol stream on link 0
`timescale 1ns/10ps
module link_far_end (
    // Clock
    input wire logic clk,
    // Link events toward the block
    output logic [7:0] rxOverflow,
    output logic [7:0] rxIllegalToken,
    output logic [7:0] creditIssuedEvt,
    output logic [7:0] creditGrantEvt,
    // Symbol stream
    output logic [7:0] symValid,
    output logic [7:0] symLast,
    input wire logic [7:0] symReady
);
    logic streamOn;
    int cyc;
    int acc[$];

    initial begin
        {rxOverflow, rxIllegalToken, creditIssuedEvt, creditGrantEvt} = '0;
        symValid = 8'h00;
        symLast = 8'h00;
        streamOn = 1'b0;
        cyc = 0;
    end

    // One-cycle event on one link; kind 0..3 picks the event line
    task automatic pulse(input int kind, input int n);
        logic [7:0] m;
        m = 8'h01 << n;
        case (kind)
            0: rxOverflow <= m;
            1: rxIllegalToken <= m;
            2: creditIssuedEvt <= m;
            default: creditGrantEvt <= m;
        endcase
        @(posedge clk);
        {rxOverflow, rxIllegalToken, creditIssuedEvt, creditGrantEvt} <= '0;
    endtask : pulse

    // Offer never withdrawn before it is taken; every second symbol ends
    always @(posedge clk) begin
        cyc++;
        if (symValid[0] && symReady[0]) begin
            acc.push_back(cyc);
            symLast[0] <= ~symLast[0];
        end
        symValid[0] <= streamOn || (symValid[0] && !symReady[0]);
    end
endmodule : link_far_end

// ### link_tx_pacer.sv
// Transmit pacing: idle gaps between symbols and between tokens
`timescale 1ns/10ps
module link_tx_pacer (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Configuration
    input wire logic enable,
    input wire logic [10:0] gapSym,
    input wire logic [10:0] gapTok,
    // Symbol handshake
    input wire logic symValid,
    input wire logic symLast,
    output logic symReady
);

    typedef struct packed {
        link_cfg_pkg::pace_e st;
        logic [10:0] cnt;
    } pace_s;

    pace_s q;
    pace_s d;
    logic accept;

    assign symReady = enable && (q.st == link_cfg_pkg::PACE_OPEN);
    assign accept = symValid && symReady;

    always_comb begin
        d = q;
        case (q.st)
            link_cfg_pkg::PACE_OPEN: begin
                if (accept) begin
                    d.st = link_cfg_pkg::PACE_WAIT;
                    d.cnt = symLast ? gapTok : gapSym; // RULE8 RULE9
                end
            end
            link_cfg_pkg::PACE_WAIT: begin
                if (q.cnt == 11'h000) begin
                    d.st = link_cfg_pkg::PACE_OPEN;
                end else begin
                    d.cnt = q.cnt - 11'h001;
                end
            end
            default: begin
                d.st = link_cfg_pkg::PACE_OPEN;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            q <= '{st: link_cfg_pkg::PACE_OPEN, cnt: link_cfg_pkg::GAP_RST};
        end else begin
            q <= d;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    // Helper: idle clocks since the last accepted symbol
    logic [11:0] sinceQ;
    logic [10:0] reqQ;
    logic prevLastQ;
    logic armedQ;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            sinceQ <= 12'h000;
            reqQ <= 11'h000;
            prevLastQ <= 1'b0;
            armedQ <= 1'b0;
        end else if (accept) begin
            sinceQ <= 12'h000;
            reqQ <= symLast ? gapTok : gapSym;
            prevLastQ <= symLast;
            armedQ <= 1'b1;
        end else if (sinceQ != 12'hfff) begin
            sinceQ <= sinceQ + 12'h001;
        end
    end

    a_sym_gap: assert property (@(posedge clk) disable iff (!nrst) // RULE8
        (accept && armedQ && !prevLastQ) |-> (sinceQ > {1'b0, reqQ}))
        else $error("symbol gap shorter than programmed");

    a_token_gap: assert property (@(posedge clk) disable iff (!nrst) // RULE9
        (accept && armedQ && prevLastQ) |-> (sinceQ > {1'b0, reqQ}))
        else $error("token gap shorter than programmed");

endmodule : link_tx_pacer

// ### testbench.sv
// Self-checking bench for the link configuration block
`timescale 1ns/10ps
`define CHK(a, b) begin nChecks++; if ((a) !== (b)) begin nMismatch++; \
    $display("[FAIL] %0t got %h want %h", $time, a, b); end end
module testbench;
    logic clk, nrst, awvalid, wvalid, bready, arvalid, rready;
    logic awready, wready, bvalid, arready, rvalid, irq;
    logic [11:0] awaddr, araddr;
    logic [31:0] wdata, rdata, rd, e;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp, rs;
    logic [7:0] linkEnable, fiveWire, greetingSend, rxResync, staticEn;
    logic [7:0] staticProc, rxOverflow, rxIllegalToken, creditIssuedEvt;
    logic [7:0] creditGrantEvt, symValid, symLast, symReady;
    logic [39:0] staticChanEnd;
    int nMismatch, nChecks, cyc, gCnt, rCnt;

    link_cfg_block dut (.clk(clk), .nrst(nrst), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
        .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
        .bresp(bresp), .arvalid(arvalid), .arready(arready),
        .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp), .linkEnable(linkEnable), .fiveWire(fiveWire),
        .greetingSend(greetingSend), .rxResync(rxResync),
        .rxOverflow(rxOverflow), .rxIllegalToken(rxIllegalToken),
        .creditIssuedEvt(creditIssuedEvt), .creditGrantEvt(creditGrantEvt),
        .symValid(symValid), .symLast(symLast), .symReady(symReady),
        .staticEn(staticEn), .staticProc(staticProc),
        .staticChanEnd(staticChanEnd), .irq(irq));

    link_far_end far (.clk(clk), .rxOverflow(rxOverflow),
        .rxIllegalToken(rxIllegalToken), .creditIssuedEvt(creditIssuedEvt),
        .creditGrantEvt(creditGrantEvt), .symValid(symValid),
        .symLast(symLast), .symReady(symReady));

    // ****************************************
    // Bus tasks
    // ****************************************
    task automatic printVerdict();
        if (nMismatch == 0 && nChecks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : printVerdict

    // Ready lines stay high, so no answer is ever missed
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        rs = bresp;
    endtask : wr

    task automatic rchk(input logic [11:0] a, input logic [31:0] x);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        rd = rdata;
        rs = rresp;
        `CHK(rd, x)
    endtask : rchk

    function automatic logic [31:0] cfg(input int n);
        return 32'h8000_0000 | (32'(n & 1) << 30) | (32'(n + 1) << 11)
            | 32'(2047 - n);
    endfunction : cfg

    // ****************************************
    // Clock, counters, timeout
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    always @(posedge clk) begin
        cyc++;
        gCnt += $countones(greetingSend);
        rCnt += $countones(rxResync);
        if (cyc == 5000) begin
            nMismatch++;
            printVerdict();
        end
    end

    // ****************************************
    // Scenarios
    // ****************************************
    initial begin
        {nrst, awvalid, wvalid, arvalid} = '0;
        {awaddr, araddr, wdata} = '0;
        {bready, rready} = 2'b11;
        wstrb = 4'hf;
        repeat (10) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rchk(12'h200, 32'h0);
        rchk(12'h280, 32'h0);
        for (int n = 0; n < 8; n++) begin
            wr(12'h200 + 12'(4 * n), cfg(n) | 32'h0180_0000);
            rchk(12'h200 + 12'(4 * n), cfg(n));
        end
        `CHK(linkEnable, 8'hff)
        `CHK(fiveWire, 8'haa)
        `CHK(gCnt, 8)
        `CHK(rCnt, 8)
        rchk(12'h220, 32'h0);
        `CHK(rs, link_cfg_pkg::RESP_SLVERR)
        wr(12'h220, 32'hffff_ffff);
        `CHK(rs, link_cfg_pkg::RESP_SLVERR)
        for (int k = 0; k < 8; k++) begin
            e = 32'h8000_0000 | (32'(k & 1) << 8) | 32'(k + 3);
            wr(12'h280 + 12'(4 * k), e | 32'h7fff_fee0);
            rchk(12'h280 + 12'(4 * k), e);
            `CHK(staticProc[k ^ 2], 1'(k & 1))
            `CHK(staticChanEnd[5 * (k ^ 2) +: 5], 5'(k + 3))
        end
        `CHK(staticEn, 8'hff)
        // Low byte only: enable and processor must survive
        wstrb <= 4'h1;
        wr(12'h280, 32'h0000_001f);
        wstrb <= 4'hf;
        `CHK(rs, link_cfg_pkg::RESP_OKAY)
        rchk(12'h280, 32'h8000_001f);
        `CHK(staticChanEnd[14:10], 5'h1f)
        // Credit and error flags on link 2, with the interrupt path
        far.pulse(3, 2);
        rchk(12'h208, cfg(2) | 32'h0200_0000);
        far.pulse(2, 2);
        rchk(12'h208, cfg(2) | 32'h0600_0000);
        far.pulse(0, 2);
        rchk(12'h208, cfg(2) | 32'h0e00_0000);
        rchk(12'h300, 32'h0000_0404);
        `CHK(irq, 1'b0)
        wr(12'h304, 32'h4);
        `CHK(irq, 1'b1)
        wr(12'h300, 32'h4);
        `CHK(irq, 1'b0)
        wr(12'h208, cfg(2) | 32'h0100_0000);
        rchk(12'h208, cfg(2) | 32'h0c00_0000);
        wr(12'h208, cfg(2) | 32'h0080_0000);
        rchk(12'h208, cfg(2) | 32'h0400_0000);
        far.pulse(1, 2);
        rchk(12'h208, cfg(2) | 32'h0c00_0000);
        wr(12'h208, 32'h0);
        rchk(12'h208, 32'h0800_0000);
        `CHK(linkEnable, 8'hfb)
        // Pacing on link 0: symbol gap field 2, token gap field 4
        wr(12'h200, 32'h8000_1004);
        far.pulse(3, 0);
        far.pulse(2, 0);
        far.pulse(1, 0);
        far.streamOn <= 1'b1;
        repeat (40) @(posedge clk);
        far.streamOn <= 1'b0;
        for (int i = 1; i < 5; i++) begin
            `CHK(far.acc[i] - far.acc[i - 1], (i % 2) ? 4 : 6)
        end
        rchk(12'h200, 32'h8e00_1004);
        printVerdict();
    end
endmodule : testbench
